// ### src/sac_core.sv
// Control port of a 7-bit step attenuator with Avalon-MM registers.
// Assumes all pins come from another domain; shift clock is sampled.
`timescale 1ns/100ps
`default_nettype none
module sac_core
  import sac_pkg::*;
#(
  parameter int unsigned PRESET_CNT = PRESET_CYCLES  // Shorten in sims
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        mode_sel,               // High serial
  input  wire logic        latch_strobe,
  input  wire logic        shift_clk,
  input  wire logic        serial_data,
  input  wire logic [6:0]  parallel_atten_inputs,
  input  wire logic        parallel_open,          // Pins left open
  input  wire logic        addr_strap_bit0,
  input  wire logic        addr_strap_bit1,
  input  wire logic        addr_strap_bit2,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [7:0]  atten_code
);
  sac_sync_if #(.W(SYNC_W)) pins ();
  sac_state_t  state_reg;      // Power-up sequencer
  logic [1:0]  init_cnt_reg;   // Lets synchronisers fill
  logic [13:0] dly_cnt_reg;    // Direct preset delay
  logic [15:0] shift_reg;      // Serial frame
  logic        sclk_d_reg;     // Previous synced shift clock
  logic        seq_done_reg;   // Bit 7 cleared once serially
  logic        direct_reg;     // Powered up in direct mode
  logic        restart;        // Soft power-up from software
  logic        mode_s, strobe_s, sclk_s, sd_s, open_s;
  logic [6:0]  par_s, par_eff;
  logic [2:0]  addr_s;
  logic        shift_edge, dly_done, run;
  logic        ser_xfer, par_xfer, addr_hit;

  assign pins.raw = {mode_sel, latch_strobe, shift_clk, serial_data,
                     parallel_open, parallel_atten_inputs,
                     addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};

  sac_sync #(.W(SYNC_W)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .s    (pins.sync_side)
  );

  assign {mode_s, strobe_s, sclk_s, sd_s, open_s, par_s, addr_s} = pins.sync;
  // Open pins read as low, giving the reference state
  assign par_eff    = open_s ? ATTEN_MIN[6:0] : par_s;
  assign shift_edge = sclk_s & ~sclk_d_reg;
  assign dly_done   = (dly_cnt_reg == 14'(PRESET_CNT - 1));
  assign run        = (state_reg == ST_RUN);
  // Serial when mode high, parallel when low
  assign addr_hit   = (shift_reg[ADDR_LSB +: 3] == addr_s);
  assign ser_xfer   = run & mode_s & strobe_s & addr_hit;
  assign par_xfer   = run & ~mode_s & strobe_s;
  assign restart    = avs_write & ~avs_waitrequest
                    & (avs_address == OFS_CTRL)
                    & avs_writedata[CTRL_RESTART];

  // Power-up sequencer; mode and strobe caught after synchronisers fill
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= ST_INIT;
      init_cnt_reg <= 2'h0;
      dly_cnt_reg  <= 14'h0000;
      direct_reg   <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        state_reg    <= ST_INIT;
        init_cnt_reg <= 2'h0;
        dly_cnt_reg  <= 14'h0000;
      end else begin
        case (state_reg)
          ST_INIT: begin
            init_cnt_reg <= init_cnt_reg + 2'h1;
            if (init_cnt_reg == 2'h2) begin
              // Parallel with strobe high means direct mode
              direct_reg <= ~mode_s & strobe_s;
              state_reg  <= (~mode_s & strobe_s) ? ST_DELAY : ST_RUN;
            end
          end
          ST_DELAY: begin
            dly_cnt_reg <= dly_cnt_reg + 14'h0001;
            if (dly_done) begin
              state_reg <= ST_RUN;
            end
          end
          ST_RUN: begin
            state_reg <= ST_RUN;  // Modes may change at will
          end
          default: begin
            state_reg <= ST_INIT;
          end
        endcase
      end
    end
  end

  // Serial shift register, LSB first; frozen while strobe high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg  <= 16'h0000;
      sclk_d_reg <= 1'b0;
    end else if (ce) begin
      sclk_d_reg <= sclk_s;
      if (shift_edge && !strobe_s) begin
        shift_reg <= {sd_s, shift_reg[FRAME_BITS-1:1]};
      end
    end
  end

  // Attenuation state; max from power-up until a transfer or the direct preset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      atten_code <= ATTEN_MAX;
    end else if (ce) begin
      if (restart || state_reg == ST_INIT) begin
        atten_code <= ATTEN_MAX;
      end else if (state_reg == ST_DELAY) begin
        // Maximum until the preset is due
        atten_code <= dly_done ? {1'b0, par_eff} : ATTEN_MAX;
      end else if (ser_xfer) begin
        atten_code <= shift_reg[7:0];
      end else if (par_xfer) begin
        // Parallel transfers keep bit 7; why the host sequences once
        atten_code <= {atten_code[7], par_eff};
      end
    end
  end

  // Tracks the one-time mode-change sequencing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_done_reg <= 1'b0;
    end else if (ce) begin
      if (ser_xfer && !shift_reg[7]) begin
        seq_done_reg <= 1'b1;  // Sticky until a restart
      end else if (restart) begin
        // A word landing with a restart still counts as sequenced
        seq_done_reg <= 1'b0;
      end
    end
  end

  // Avalon slave: one wait cycle, answer on the next edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= RDATA_RESET;
    end else if (ce) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= RDATA_RESET;
        if (avs_read && avs_address == OFS_STATUS) begin
          avs_readdata[7:0]           <= atten_code;
          avs_readdata[ST_MODE_BIT]   <= mode_s;
          avs_readdata[ST_BUSY_BIT]   <= ~run;
          avs_readdata[ST_SEQ_BIT]    <= seq_done_reg;
          avs_readdata[ST_DIRECT_BIT] <= direct_reg;
        end
      end else begin
        // Unmapped reads return zero, unmapped writes are dropped
        avs_waitrequest <= 1'b1;
      end
    end
  end

  property p_run_hold;
    @(posedge clk) disable iff (!nrst)
    (ce && run && !ser_xfer && !par_xfer && !restart) |=> $stable(atten_code);
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("Attenuation moved without a transfer");

  property p_preset;
    @(posedge clk) disable iff (!nrst)
    (ce && state_reg == ST_DELAY && dly_done && !restart)
      |=> (run && atten_code == {1'b0, $past(par_eff)});
  endproperty
  a_preset: assert property (p_preset)
    else $error("Direct preset not applied after the delay");

  property p_delay_max;
    @(posedge clk) disable iff (!nrst)
    (state_reg == ST_DELAY && dly_cnt_reg != 14'h0000)
      |-> atten_code == ATTEN_MAX;
  endproperty
  a_delay_max: assert property (p_delay_max)
    else $error("Not at maximum during the preset delay");

  property p_open_min;
    @(posedge clk) disable iff (!nrst)
    (ce && state_reg == ST_DELAY && dly_done && open_s && !restart)
      |=> atten_code == ATTEN_MIN;
  endproperty
  a_open_min: assert property (p_open_min)
    else $error("Open pins did not give minimum attenuation");

  property p_shift;
    @(posedge clk) disable iff (!nrst)
    (ce && shift_edge && !strobe_s)
      |=> shift_reg == {$past(sd_s), $past(shift_reg[15:1])};
  endproperty
  a_shift: assert property (p_shift)
    else $error("Shift register did not take the data bit");

  property p_ser_xfer;
    @(posedge clk) disable iff (!nrst)
    (ce && ser_xfer && !restart) |=> atten_code == $past(shift_reg[7:0]);
  endproperty
  a_ser_xfer: assert property (p_ser_xfer)
    else $error("Matching serial word not transferred");

  property p_addr_miss;
    @(posedge clk) disable iff (!nrst)
    (ce && run && mode_s && !addr_hit && !restart) |=> $stable(atten_code);
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("State changed on an address mismatch");

  property p_direct;
    @(posedge clk) disable iff (!nrst)
    (ce && par_xfer && !restart) ##1 (ce && par_xfer && !restart)
      |=> atten_code[6:0] == $past(par_eff);
  endproperty
  a_direct: assert property (p_direct)
    else $error("Parallel inputs not passed through");

  property p_seq_sticky;
    @(posedge clk) disable iff (!nrst)
    (seq_done_reg && !restart) |=> seq_done_reg;
  endproperty
  a_seq_sticky: assert property (p_seq_sticky)
    else $error("Sequencing flag dropped");
endmodule
`default_nettype wire

// ### inc/sac_pkg.sv
// Constants shared by the step attenuator control port.
// Assumes a 25 MHz system clock; the reset release counts as power-up.
// Contract
// - Power-up serial or latched: maximum until latched
// - Direct mode applies preset after fixed delay
// - Hold maximum during direct power-up delay
// - Open parallel pins settle at minimum attenuation
// - Serial and parallel modes switch during operation
// - Sequencing once; afterwards modes switch freely
// - Strobe low: shift clock rise shifts data
// - Strobe high: shift register drives attenuator
// - Mode select low parallel, high serial
// - Sixteen bits LSB first, attenuation then address
// - Latch only when address matches strap inputs
// - Code equals decibels times four, binary
package sac_pkg;
  // Timing of the direct-mode preset, and synchroniser width
  localparam int unsigned CLK_MHZ          = 25;
  localparam int unsigned PRESET_DELAY_US  = 400;
  localparam int unsigned PRESET_CYCLES    = PRESET_DELAY_US * CLK_MHZ;
  localparam int unsigned SYNC_W           = 15;
  // Codes are quarter decibels: 31.75 dB is 127
  localparam logic [7:0]  ATTEN_MAX        = 8'h7F;
  localparam logic [7:0]  ATTEN_MIN        = 8'h00;
  localparam int unsigned FRAME_BITS       = 16;
  localparam int unsigned ADDR_LSB         = 8;
  // Avalon byte offsets and fields
  localparam logic [3:0]  OFS_CTRL         = 4'h0;
  localparam logic [3:0]  OFS_STATUS       = 4'h4;
  localparam int unsigned CTRL_RESTART     = 0;
  localparam int unsigned ST_MODE_BIT      = 8;
  localparam int unsigned ST_BUSY_BIT      = 9;
  localparam int unsigned ST_SEQ_BIT       = 10;
  localparam int unsigned ST_DIRECT_BIT    = 11;
  localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;
  // Power-up sequencer, one-hot
  typedef enum logic [2:0] {
    ST_INIT  = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN   = 3'b100
  } sac_state_t;
endpackage

// ### inc/sac_sync_if.sv
// Carrier between the pin synchroniser and the control logic.
// Assumes the top drives raw from its pins and reads sync.
`timescale 1ns/100ps
`default_nettype none
interface sac_sync_if #(parameter int unsigned W = 1);
  logic [W-1:0] raw;   // Straight from pins
  logic [W-1:0] sync;  // After two flops
  modport sync_side (input raw, output sync);
  modport user      (output raw, input sync);
endinterface
`default_nettype wire

// ### src/sac_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes the enable freezes it like the rest of the block.
`timescale 1ns/100ps
`default_nettype none
module sac_sync
  import sac_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic    clk,
  input  wire logic    nrst,
  input  wire logic    ce,
  sac_sync_if.sync_side s
);
  logic [W-1:0] meta_reg;  // First stage, read only by second
  logic [W-1:0] sync_reg;  // Second stage, safe to use

  // Both stages clear to constants on reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (ce) begin
      meta_reg <= s.raw;
      sync_reg <= meta_reg;
    end
  end

  assign s.sync = sync_reg;
endmodule
`default_nettype wire

// ### tb/sac_host_model.sv
// Host controller model driving the attenuator control pins.
// Assumes a 25 MHz clk; shift clock period is 8 clk (320 ns).
`timescale 1ns/100ps
`default_nettype none
module sac_host_model (
  input  wire logic       clk,
  output logic            mode_sel,
  output logic            strobe,
  output logic            sck,
  output logic            sdata,
  output logic [6:0]      par,
  output logic            par_open
);
  // Serial power-up with parallel pins low
  initial begin
    mode_sel = 1'b1;
    strobe   = 1'b0;
    sck      = 1'b0;
    sdata    = 1'b0;
    par      = 7'h00;
    par_open = 1'b0;
  end
  // Pin levels; callers keep pins low until bit7 is cleared
  task automatic pins(input logic m, s, input logic [6:0] p, input logic o);
    mode_sel <= m;
    strobe   <= s;
    par      <= p;
    par_open <= o;
  endtask
  // Frame LSB first, attenuation then address
  task automatic send(input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      sdata <= w[i];
      sck   <= 1'b0;
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
    end
    sck   <= 1'b0;
    sdata <= ~w[15];  // Hold time over: no stale level
    repeat (4) @(posedge clk);
    strobe <= 1'b1;
    repeat (8) @(posedge clk);
    strobe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### tb/step_attenuator_control_port_tb_top.sv
// Self-checking bench for the attenuator control port.
// Assumes sac_core with a short preset count and the host model.
`timescale 1ns/100ps
`default_nettype none
module step_attenuator_control_port_tb_top;
  import sac_pkg::*;
  localparam int unsigned PCNT = 20;  // Short preset delay
  logic        clk, nrst, ce, ms, ls, sck, sd, po, rd, wr, wq;
  logic [6:0]  pin;
  logic [3:0]  adr;
  logic [31:0] wd, rdat, q;
  logic [7:0]  atten;
  int          error_cnt, samples_checked;
  // Serial rows: frame word and expected code, straps are 5
  logic [15:0] fr [5] = '{16'hFD49, 16'h0500, 16'h057F, 16'h0412, 16'h0526};
  logic [7:0]  ex [5] = '{8'h49, 8'h00, 8'h7F, 8'h7F, 8'h26};
  sac_host_model host (.clk(clk), .mode_sel(ms), .strobe(ls), .sck(sck),
    .sdata(sd), .par(pin), .par_open(po));
  sac_core #(.PRESET_CNT(PCNT)) dut (.clk(clk), .nrst(nrst), .ce(ce),
    .mode_sel(ms), .latch_strobe(ls), .shift_clk(sck), .serial_data(sd),
    .parallel_atten_inputs(pin), .parallel_open(po),
    .addr_strap_bit0(1'b1), .addr_strap_bit1(1'b0), .addr_strap_bit2(1'b1),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wq), .atten_code(atten));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    rd  <= ~w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (wq !== 1'b0) begin
      error_cnt++;
      summarize();
    end
    // Read data stand at the edge that sees waitrequest low
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Hang guard
  initial begin
    #3000000;
    error_cnt++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    ce   = 1'b1;
    {rd, wr, adr, wd} = '0;
    repeat (4) @(posedge clk);
    check(atten, ATTEN_MAX);
    check({31'h0000_0000, wq}, 32'h0000_0001);
    check(rdat, RDATA_RESET);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    check(atten, ATTEN_MAX);
    // Serial rows, one miss on the address
    for (int i = 0; i < 5; i++) begin
      host.send(fr[i]);
      check(atten, ex[i]);
    end
    // Status: serial, running, a bit7-low word seen
    bus(1'b0, OFS_STATUS, 32'h0);
    check(q, 32'h0000_0526);
    // Enable low freezes the block: this frame is lost
    ce <= 1'b0;
    host.send(16'h0511);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    check(atten, 8'h26);
    // Latched parallel after bit7 cleared
    host.pins(1'b0, 1'b0, 7'h2A, 1'b0);
    repeat (8) @(posedge clk);
    check(atten, 8'h26);  // Not latched yet
    host.pins(1'b0, 1'b1, 7'h2A, 1'b0);
    repeat (8) @(posedge clk);
    host.pins(1'b0, 1'b0, 7'h11, 1'b0);
    repeat (8) @(posedge clk);
    check(atten, 8'h2A);
    // Direct mode follows the pins
    host.pins(1'b0, 1'b1, 7'h11, 1'b0);
    repeat (8) @(posedge clk);
    check(atten, 8'h11);
    host.pins(1'b0, 1'b1, 7'h6C, 1'b0);
    repeat (8) @(posedge clk);
    check(atten, 8'h6C);
    // Back to serial freely
    host.pins(1'b1, 1'b0, 7'h00, 1'b0);
    repeat (8) @(posedge clk);
    host.send(16'h0533);
    check(atten, 8'h33);
    // Direct power-up preset through a soft restart
    host.pins(1'b0, 1'b1, 7'h3C, 1'b0);
    repeat (8) @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (6) @(posedge clk);
    check(atten, ATTEN_MAX);
    bus(1'b0, OFS_STATUS, 32'h0);
    check(q, 32'h0000_0A7F);
    // Three sequencer edges, then the delay: last edge still at maximum
    repeat (PCNT - 6) @(posedge clk);
    check(atten, ATTEN_MAX);
    repeat (2) @(posedge clk);
    check(atten, 8'h3C);
    // Open pins settle at minimum
    host.pins(1'b0, 1'b1, 7'h55, 1'b1);
    repeat (8) @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (6) @(posedge clk);
    check(atten, ATTEN_MAX);
    repeat (2 * PCNT) @(posedge clk);
    check(atten, ATTEN_MIN);
    // Unmapped read gives zero
    bus(1'b0, 4'h8, 32'h0);
    check(q, 32'h0000_0000);
    // Power-up again through the reset pin, direct with a preset
    host.pins(1'b0, 1'b1, 7'h55, 1'b0);
    repeat (8) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    check(atten, ATTEN_MAX);
    check({31'h0000_0000, wq}, 32'h0000_0001);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    check(atten, ATTEN_MAX);
    repeat (2 * PCNT) @(posedge clk);
    check(atten, 8'h55);
    summarize();
  end
endmodule
`default_nettype wire
